// ### logic/fdc_core.sv
// fifo and direct command controller of the reader, core clock side
// assumes serial port on its own clock, framing and analog blocks on core_clk
`timescale 1ns/1ps
`include "fdc_consts.svh"
module fdc_core import fdc_pkg::*; #(
  parameter int DEPTH = `FDC_DEPTH,
  parameter int TXW = 10
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input fdc_cfg_t cfg,
  input wire logic mask_wl,
  input wire logic mask_cmd,
  input wire logic rx_wr,
  input wire logic [7:0] rx_data,
  input wire logic tx_rd,
  output logic [7:0] tx_data,
  input wire logic [TXW-1:0] tx_total,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic act_done,
  output fdc_cmd_t cmd,
  output logic rx_ignore,
  output logic [6:0] fifo_count,
  output logic ovf,
  output logic unf,
  output logic irq
);

  localparam int AW = 7;
  localparam logic [AW-1:0] FULL = AW'(DEPTH);

  function automatic logic [AW-1:0] step(input logic [AW-1:0] p);
    return (p == FULL - 7'h01) ? 7'h00 : p + 7'h01;
  endfunction : step

  // ****************************************
  // link crossing
  // ****************************************
  logic ss_s1;
  logic ss_s2;
  logic tg_s1;
  logic tg_s2;
  logic tg_s3;
  logic rx_tgl;
  logic [7:0] link_byte;
  logic byte_evt;
  fdc_regs_t regs;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
      tg_s1 <= 1'b0;
      tg_s2 <= 1'b0;
      tg_s3 <= 1'b0;
    end else begin
      ss_s1 <= ss_n;
      ss_s2 <= ss_s1;
      tg_s1 <= rx_tgl;
      tg_s2 <= tg_s1;
      tg_s3 <= tg_s2;
    end
  end

  // link_byte is held a full byte time after its toggle
  assign byte_evt = tg_s2 ^ tg_s3;

  fdc_link u_link (
    .sclk(sclk),
    .arst_n(arst_n),
    .ss_n(ss_n),
    .mosi(mosi),
    .fifo_head(tx_data),
    .regs(regs),
    .rx_byte(link_byte),
    .rx_tgl(rx_tgl),
    .miso(miso),
    .miso_oe(miso_oe)
  );

  // ****************************************
  // transfer state
  // ****************************************
  fdc_state_t state;
  logic [5:0] reg_addr;
  logic fifo_busy;
  fdc_cmd_t next_cmd;
  logic cmd_ok;
  logic cmd_chain;
  logic cmd_irq;

  assign fifo_busy = (state == ST_LOAD) || (state == ST_DRAIN);

  always_comb begin
    next_cmd = '0;
    cmd_ok = 1'b0;
    cmd_chain = 1'b1;
    cmd_irq = 1'b0;
    if (byte_evt && state == ST_HEAD && fdc_mode(link_byte) == FDC_M_CMD) begin
      case (link_byte)
        `FDC_C_SET_DEFAULT: begin
          cmd_ok = 1'b1;
          cmd_chain = 1'b0;
          next_cmd.set_default = 1'b1;
        end
        `FDC_C_CLEAR0, `FDC_C_CLEAR1: begin
          cmd_ok = cfg.en;
          next_cmd.clear = 1'b1;
        end
        `FDC_C_TX_CRC, `FDC_C_TX_PLAIN: begin
          cmd_ok = cfg.en && cfg.tx_en;
          next_cmd.tx_crc = link_byte == `FDC_C_TX_CRC;
          next_cmd.tx_plain = link_byte == `FDC_C_TX_PLAIN;
        end
        `FDC_C_TX_REQA, `FDC_C_TX_WUPA: begin
          cmd_ok = cfg.en && cfg.tx_en && cfg.iso_a;
          next_cmd.tx_reqa = link_byte == `FDC_C_TX_REQA;
          next_cmd.tx_wupa = link_byte == `FDC_C_TX_WUPA;
        end
        `FDC_C_FIELD_INIT, `FDC_C_FIELD_RESP, `FDC_C_FIELD_RESP0: begin
          cmd_ok = cfg.en;
          cmd_irq = 1'b1;
          next_cmd.field_init = link_byte == `FDC_C_FIELD_INIT;
          next_cmd.field_resp = link_byte == `FDC_C_FIELD_RESP;
          next_cmd.field_resp0 = link_byte == `FDC_C_FIELD_RESP0;
        end
        `FDC_C_RX_MASK, `FDC_C_RX_UNMASK: begin
          cmd_ok = cfg.en && cfg.rx_en;
          next_cmd.rx_mask = link_byte == `FDC_C_RX_MASK;
          next_cmd.rx_unmask = link_byte == `FDC_C_RX_UNMASK;
        end
        `FDC_C_MEAS_AMP: begin
          cmd_ok = cfg.en;
          cmd_chain = 1'b0;
          cmd_irq = 1'b1;
          next_cmd.meas_amp = 1'b1;
        end
        `FDC_C_SQUELCH: begin
          cmd_ok = cfg.en && cfg.rx_en;
          cmd_chain = 1'b0;
          next_cmd.squelch = 1'b1;
        end
        default: cmd_ok = 1'b0;
      endcase
      if (!cmd_ok) begin
        next_cmd = '0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      reg_addr <= 6'h00;
    end else if (ss_s2) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= ST_HEAD;
        ST_HEAD: begin
          if (byte_evt) begin
            reg_addr <= link_byte[5:0];
            case (fdc_mode(link_byte))
              FDC_M_FIFO: begin
                if (fdc_is_fifo_read(link_byte)) begin
                  state <= ST_DRAIN;
                end else if (link_byte[5:0] == `FDC_FIFO_LOAD) begin
                  state <= ST_LOAD;
                end else begin
                  state <= ST_LOCK;
                end
              end
              FDC_M_READ: state <= ST_REGRD;
              FDC_M_CMD: state <= (cmd_ok && !cmd_chain) ? ST_LOCK : ST_HEAD;
              default: state <= ST_LOCK;
            endcase
          end
        end
        ST_LOAD, ST_DRAIN, ST_REGRD, ST_LOCK: state <= state;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // fifo
  // ****************************************
  logic [AW-1:0] count;
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] next_count;
  logic [AW-1:0] next_rd_ptr;
  logic [TXW-1:0] loaded;
  logic push_host;
  logic push;
  logic pop;
  logic do_push;
  logic do_pop;
  logic clr_fifo;

  assign push_host = byte_evt && state == ST_LOAD;
  assign push = push_host || rx_wr;
  // a byte counts as read only once all eight bits went out
  assign pop = (byte_evt && state == ST_DRAIN) || tx_rd;
  assign do_push = push && count != FULL;
  assign do_pop = pop && count != 7'h00;
  // set default leaves the fifo alone without main enable
  assign clr_fifo = next_cmd.clear || (next_cmd.set_default && cfg.en);

  always_comb begin
    next_count = count;
    next_rd_ptr = do_pop ? step(rd_ptr) : rd_ptr;
    if (clr_fifo) begin
      next_count = 7'h00;
      next_rd_ptr = 7'h00;
    end else if (do_push && !do_pop) begin
      next_count = count + 7'h01;
    end else if (do_pop && !do_push) begin
      next_count = count - 7'h01;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count <= 7'h00;
      wr_ptr <= 7'h00;
      rd_ptr <= 7'h00;
      loaded <= '0;
    end else begin
      count <= next_count;
      rd_ptr <= next_rd_ptr;
      if (clr_fifo) begin
        wr_ptr <= 7'h00;
        loaded <= '0;
      end else begin
        wr_ptr <= do_push ? step(wr_ptr) : wr_ptr;
        loaded <= (do_push && push_host) ? loaded + 1'b1 : loaded;
      end
    end
  end

  // receiver wins a write collision; both sides never run at once
  fdc_mem #(.W(8), .DEPTH(DEPTH), .AW(AW)) u_mem (
    .clk(core_clk),
    .arst_n(arst_n),
    .we(do_push && !clr_fifo),
    .waddr(wr_ptr),
    .wdata(rx_wr ? rx_data : link_byte),
    .raddr(next_rd_ptr),
    .rdata(tx_data)
  );

  assign fifo_count = count;

  // ****************************************
  // water level and flags
  // ****************************************
  logic [AW-1:0] wl_rx;
  logic [AW-1:0] wl_tx;
  logic all_loaded;
  logic wl_evt;
  logic irq_wl;
  logic irq_cmd;
  logic pend;
  logic irq_rd;
  logic s2_rd;

  assign wl_rx = cfg.wl_rx_sel ? `FDC_WL_RX1 : `FDC_WL_RX0;
  assign wl_tx = cfg.wl_tx_sel ? `FDC_WL_TX1 : `FDC_WL_TX0;
  assign all_loaded = loaded >= tx_total;
  assign wl_evt = !fifo_busy && !clr_fifo && (
    (tx_active && !all_loaded && count == wl_tx + 7'h01 && next_count == wl_tx) ||
    (tx_active && !all_loaded && loaded < TXW'(wl_tx) &&
      count == `FDC_DROP_LEVEL && next_count == `FDC_DROP_LEVEL - 7'h01) ||
    (rx_active && count == wl_rx - 7'h01 && next_count == wl_rx));
  assign irq_rd = byte_evt && state == ST_REGRD && reg_addr == `FDC_ADDR_IRQ;
  assign s2_rd = byte_evt && state == ST_REGRD && reg_addr == `FDC_ADDR_STAT2;

  // a new event in the clearing cycle is kept
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf <= 1'b0;
      unf <= 1'b0;
    end else begin
      ovf <= (push && count == FULL) || (ovf && !s2_rd && !clr_fifo);
      unf <= (pop && count == 7'h00) || (unf && !s2_rd && !clr_fifo);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_wl <= 1'b0;
      irq_cmd <= 1'b0;
      pend <= 1'b0;
    end else begin
      irq_wl <= wl_evt || (irq_wl && !irq_rd && !clr_fifo);
      irq_cmd <= (act_done && pend) || (irq_cmd && !irq_rd && !clr_fifo);
      pend <= (cmd_ok && cmd_irq) || (pend && !act_done);
    end
  end

  // masks only gate the pin, flags still set
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= (irq_wl && !mask_wl) || (irq_cmd && !mask_cmd);
    end
  end

  // ****************************************
  // outputs and register snapshot
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= '0;
      rx_ignore <= 1'b0;
      regs <= '0;
    end else begin
      cmd <= next_cmd;
      if (next_cmd.rx_mask) begin
        rx_ignore <= 1'b1;
      end else if (next_cmd.rx_unmask || next_cmd.set_default) begin
        rx_ignore <= 1'b0;
      end
      regs.stat1 <= 8'(count);
      regs.stat2 <= 8'({ovf, 5'h00}) | 8'({unf, 6'h00});
      regs.irq <= 8'({irq_wl, 7'h00}) | 8'({irq_cmd, 6'h00});
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  AST_DEPTH: assert property (count <= FULL && wr_ptr == AW'((rd_ptr + count) % DEPTH))
    else $error("fifo count beyond depth");
  AST_OVF: assert property (push && count == FULL |=> ovf && count == FULL)
    else $error("overflow not flagged");
  AST_UNF: assert property (pop && count == 7'h00 |=>
    unf ##1 (unf || $past(s2_rd || clr_fifo)))
    else $error("underflow not flagged");
  AST_RX_WL: assert property (rx_active && !fifo_busy && !clr_fifo &&
    count == wl_rx - 7'h01 && do_push && !do_pop |=> irq_wl)
    else $error("receive water level irq missing");
  AST_TX_WL: assert property (tx_active && !all_loaded && !fifo_busy && !clr_fifo &&
    count == wl_tx + 7'h01 && do_pop && !do_push |=> irq_wl)
    else $error("transmit water level irq missing");
  AST_QUIET: assert property ($rose(irq_wl) |-> $past(!fifo_busy))
    else $error("level irq during fifo transfer");
  AST_MASK: assert property (irq |-> $past(irq_wl && !mask_wl || irq_cmd && !mask_cmd))
    else $error("irq pin without unmasked flag");
  AST_REJECT: assert property (byte_evt && state == ST_HEAD &&
    link_byte == `FDC_C_TX_CRC && !cfg.tx_en |=> cmd == '0 && state == ST_HEAD || ss_s2)
    else $error("command taken without enables");
  AST_STICKY: assert property (ovf && !s2_rd && !clr_fifo |=> ovf)
    else $error("overflow flag lost");
  AST_SETDEF: assert property (cmd_ok && link_byte == `FDC_C_SET_DEFAULT
    |=> cmd.set_default && !irq_cmd ##1 !cmd.set_default)
    else $error("set default not pulsed");
  AST_LOCK: assert property (cmd_ok && !cmd_chain && !ss_s2 |=> state == ST_LOCK)
    else $error("unchainable command did not lock the transfer");

endmodule : fdc_core

// ### logic/fdc_consts.svh
// constants for the fifo and direct command controller
// assumes inclusion by bare name from the package and the modules
`ifndef FDC_CONSTS_SVH
`define FDC_CONSTS_SVH

`define FDC_DEPTH 7'h60
`define FDC_DROP_LEVEL 7'h04

// two water level settings per direction
`define FDC_WL_RX0 7'h40
`define FDC_WL_RX1 7'h50
`define FDC_WL_TX0 7'h20
`define FDC_WL_TX1 7'h10

// readable register addresses of the serial port
`define FDC_ADDR_IRQ 6'h17
`define FDC_ADDR_STAT1 6'h1A
`define FDC_ADDR_STAT2 6'h1B
`define FDC_IRQ_WL 7
`define FDC_IRQ_CMD 6
`define FDC_S2_UNF 6
`define FDC_S2_OVF 5

// fifo sub-codes after mode bits 10
`define FDC_FIFO_LOAD 6'h00
`define FDC_FIFO_READ 6'h3F

// direct command bytes
`define FDC_C_SET_DEFAULT 8'hC1
`define FDC_C_CLEAR0 8'hC2
`define FDC_C_CLEAR1 8'hC3
`define FDC_C_TX_CRC 8'hC4
`define FDC_C_TX_PLAIN 8'hC5
`define FDC_C_TX_REQA 8'hC6
`define FDC_C_TX_WUPA 8'hC7
`define FDC_C_FIELD_INIT 8'hC8
`define FDC_C_FIELD_RESP 8'hC9
`define FDC_C_FIELD_RESP0 8'hCA
`define FDC_C_RX_MASK 8'hD0
`define FDC_C_RX_UNMASK 8'hD1
`define FDC_C_MEAS_AMP 8'hD3
`define FDC_C_SQUELCH 8'hD4

`endif

// ### logic/fdc_pkg.sv
// types and shared decoding for the fifo and direct command controller
// assumes fdc_consts.svh is on the include path
`include "fdc_consts.svh"
package fdc_pkg;

  typedef enum logic [1:0] {
    FDC_M_WRITE = 2'h0,
    FDC_M_READ = 2'h1,
    FDC_M_FIFO = 2'h2,
    FDC_M_CMD = 2'h3
  } fdc_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HEAD = 3'h1,
    ST_LOAD = 3'h3,
    ST_DRAIN = 3'h2,
    ST_REGRD = 3'h6,
    ST_LOCK = 3'h7
  } fdc_state_t;

  typedef struct packed {
    logic en;
    logic tx_en;
    logic rx_en;
    logic iso_a;
    logic wl_rx_sel;
    logic wl_tx_sel;
  } fdc_cfg_t;

  typedef struct packed {
    logic set_default;
    logic clear;
    logic tx_crc;
    logic tx_plain;
    logic tx_reqa;
    logic tx_wupa;
    logic field_init;
    logic field_resp;
    logic field_resp0;
    logic rx_mask;
    logic rx_unmask;
    logic meas_amp;
    logic squelch;
  } fdc_cmd_t;

  typedef struct packed {
    logic [7:0] stat1;
    logic [7:0] stat2;
    logic [7:0] irq;
  } fdc_regs_t;

  function automatic fdc_mode_t fdc_mode(input logic [7:0] b);
    return fdc_mode_t'(b[7:6]);
  endfunction : fdc_mode

  function automatic logic fdc_is_fifo_read(input logic [7:0] b);
    return (fdc_mode(b) == FDC_M_FIFO) && (b[5:0] == `FDC_FIFO_READ);
  endfunction : fdc_is_fifo_read

endpackage : fdc_pkg

// ### logic/fdc_mem.sv
// byte storage of the fifo, one write port and a registered read port
// assumes the caller keeps addresses below DEPTH
`timescale 1ns/1ps
`include "fdc_consts.svh"
module fdc_mem #(
  parameter int W = 8,
  parameter int DEPTH = `FDC_DEPTH,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [W-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [W-1:0] rdata
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule : fdc_mem

// ### logic/fdc_link.sv
// serial port end on the serial clock: bytes in, fifo or register data out
// assumes mosi sampled on the falling edge, miso changed on the rising edge
`timescale 1ns/1ps
`include "fdc_consts.svh"
module fdc_link import fdc_pkg::*; (
  input wire logic sclk,
  input wire logic arst_n,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [7:0] fifo_head,
  input fdc_regs_t regs,
  output logic [7:0] rx_byte,
  output logic rx_tgl,
  output logic miso,
  output logic miso_oe
);

  logic lrst;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic [6:0] tx_sh;
  logic head_done;
  logic rd_fifo;
  logic rd_reg;
  logic [5:0] addr;
  logic [7:0] load;

  // slave select high ends every transfer
  assign lrst = ss_n | ~arst_n;

  // ****************************************
  // receive side
  // ****************************************
  always_ff @(negedge sclk or posedge lrst) begin
    if (lrst) begin
      bit_cnt <= 3'h0;
      shift <= 7'h00;
      head_done <= 1'b0;
      rd_fifo <= 1'b0;
      rd_reg <= 1'b0;
      addr <= 6'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= {shift[5:0], mosi};
      if (bit_cnt == 3'h7 && !head_done) begin
        // a command byte leaves the next byte as a new head
        head_done <= fdc_mode({shift, mosi}) != FDC_M_CMD;
        rd_fifo <= fdc_is_fifo_read({shift, mosi});
        rd_reg <= fdc_mode({shift, mosi}) == FDC_M_READ;
        addr <= {shift[4:0], mosi};
      end
    end
  end

  // toggle survives slave select so the core sees each event once
  always_ff @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      rx_byte <= 8'h00;
      rx_tgl <= 1'b0;
    end else if (!ss_n && bit_cnt == 3'h7) begin
      rx_byte <= {shift, mosi};
      rx_tgl <= ~rx_tgl;
    end
  end

  // ****************************************
  // transmit side
  // ****************************************
  // head and regs are refreshed by the core every core clock and taken at a byte's first rising edge
  always_comb begin
    load = fifo_head;
    if (!rd_fifo) begin
      case (addr)
        `FDC_ADDR_STAT1: load = regs.stat1;
        `FDC_ADDR_STAT2: load = regs.stat2;
        `FDC_ADDR_IRQ: load = regs.irq;
        default: load = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sclk or posedge lrst) begin
    if (lrst) begin
      miso <= 1'b0;
      miso_oe <= 1'b0;
      tx_sh <= 7'h00;
    end else if (bit_cnt == 3'h0 && head_done && (rd_fifo || rd_reg)) begin
      miso <= load[7];
      tx_sh <= load[6:0];
      miso_oe <= 1'b1;
    end else begin
      miso <= tx_sh[6];
      tx_sh <= {tx_sh[5:0], 1'b0};
    end
  end

endmodule : fdc_link

// ### test/fdc_host.sv
// serial port host model that drives the controller's link pins
// assumes the bench calls open_frame, shift and close_frame in order
`timescale 1ns/1ps
module fdc_host (
  output logic sclk,
  output logic ss_n,
  output logic mosi,
  input wire logic miso
);
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  task automatic open_frame();
    ss_n = 1'b0;
    #20;
  endtask : open_frame
  // 12 ns period, msb first; the pause after a byte lets the core catch up
  task automatic shift(input logic [7:0] v, input int n, output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < n; i++) begin
      // data moves mid-low so the falling edge never races it
      #3 mosi = v[7-i];
      #3 sclk = 1'b1;
      #6 r = {r[6:0], miso};
      sclk = 1'b0;
    end
    #100;
  endtask : shift
  // released data line shows the inverse of its last bit
  task automatic close_frame();
    ss_n = 1'b1;
    mosi = ~mosi;
    #60;
  endtask : close_frame
endmodule : fdc_host

// ### test/tb.sv
// self-checking bench of the fifo and direct command controller
// assumes fdc_host plays the serial port master
`timescale 1ns/1ps
module tb import fdc_pkg::*; ;
  logic core_clk, arst_n, sclk, ss_n, mosi, miso;
  fdc_cfg_t cfg;
  fdc_cmd_t cmd;
  logic mask_wl, rx_wr, tx_rd, tx_active, rx_active, rx_ignore, ovf, unf, irq;
  logic [7:0] rx_data, tx_data, r;
  logic [9:0] tx_total;
  logic [6:0] fifo_count;
  logic [12:0] seen;
  logic mask_cmd, act_done, miso_oe, seen_clr;
  logic [7:0] code [14] = '{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8,
    8'hC9, 8'hCA, 8'hD0, 8'hD1, 8'hD3, 8'hD4};
  // required enables {en, tx_en, rx_en, iso_a}
  logic [3:0] need [14] = '{4'h0, 4'h8, 4'h8, 4'hC, 4'hC, 4'hD, 4'hD, 4'h8, 4'h8, 4'h8,
    4'hA, 4'hA, 4'h8, 4'hA};
  logic [3:0] have [3] = '{4'h0, 4'h8, 4'hF};
  logic acc;
  int miscompares, num_checks, cycles, sh;

  fdc_core #(.TXW(10)) uut (.core_clk(core_clk), .arst_n(arst_n), .sclk(sclk),
    .ss_n(ss_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .cfg(cfg), .mask_wl(mask_wl),
    .mask_cmd(mask_cmd), .rx_wr(rx_wr), .rx_data(rx_data), .tx_rd(tx_rd), .tx_data(tx_data),
    .tx_total(tx_total), .tx_active(tx_active), .rx_active(rx_active), .act_done(act_done),
    .cmd(cmd), .rx_ignore(rx_ignore), .fifo_count(fifo_count), .ovf(ovf), .unf(unf),
    .irq(irq));
  fdc_host host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(miso));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) seen <= seen_clr ? 13'h0000 : seen | cmd;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  // rx_wr held high across the burst, one byte per cycle
  task automatic push(input logic [7:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      rx_data = base + 8'(i);
      rx_wr = 1'b1;
      cyc(1);
    end
    rx_wr = 1'b0;
    cyc(1);
  endtask : push
  task automatic spi(input logic [7:0] hd, input int n, output logic [7:0] d);
    host.open_frame();
    host.shift(hd, 8, d);
    if (n > 0) host.shift(8'h00, n, d);
    host.close_frame();
    cyc(8);
  endtask : spi
  task automatic pop(input int n);
    tx_rd = 1'b1;
    cyc(n);
    tx_rd = 1'b0;
    cyc(3);
  endtask : pop

  initial begin
    {arst_n, mask_wl, mask_cmd, act_done, rx_wr, tx_rd, tx_active, rx_active} = '0;
    {cfg, rx_data, tx_total} = '0;
    seen_clr = 1'b1;
    cyc(2);
    arst_n = 1'b1;
    cyc(3);
    chk({fifo_count, ovf, unf, irq, rx_ignore}, 13'h0000);
    foreach (have[p]) begin
      cfg = fdc_cfg_t'({have[p], 2'b00});
      for (int i = 0; i < 15; i++) begin
        seen_clr = 1'b1;
        cyc(1);
        seen_clr = 1'b0;
        spi(i < 14 ? code[i] : 8'hD2, 0, r);
        acc = i < 14 && (need[i % 14] & ~have[p]) == 4'h0;
        // C2 and C3 share the clear pulse
        sh = i - int'(i > 1);
        chk(seen, acc ? 13'h1000 >> sh : 13'h0000);
        if (i == 10) chk(rx_ignore, acc);
      end
    end
    // long commands finish: flag and pin, then the pin masked
    act_done = 1'b1;
    cyc(1);
    act_done = 1'b0;
    cyc(1);
    chk(irq, 1'b1);
    mask_cmd = 1'b1;
    cyc(1);
    chk(irq, 1'b0);
    // receive side, threshold 64, level irq masked
    cfg = fdc_cfg_t'(6'b101000);
    rx_active = 1'b1;
    mask_wl = 1'b1;
    push(8'h00, 64);
    chk({fifo_count, irq}, {7'h40, 1'b0});
    spi(8'h57, 8, r);
    chk(r, 8'hC0);
    spi(8'h57, 8, r);
    chk(r, 8'h00);
    push(8'h40, 33);
    chk({fifo_count, ovf}, {7'h60, 1'b1});
    spi(8'h5A, 8, r);
    chk(r, 8'h60);
    spi(8'h5B, 8, r);
    chk({r, ovf}, {8'h20, 1'b0});
    // read one byte, then cut the next one short
    host.open_frame();
    host.shift(8'hBF, 8, r);
    host.shift(8'h00, 8, r);
    chk({r, miso_oe}, {8'h00, 1'b1});
    host.shift(8'h00, 4, r);
    host.close_frame();
    spi(8'hBF, 8, r);
    chk({r, fifo_count, miso_oe}, {8'h01, 7'h5E, 1'b0});
    spi(8'hC2, 0, r);
    chk(fifo_count, 7'h00);
    pop(1);
    chk(unf, 1'b1);
    // transmit side, threshold 16, 40 byte frame
    {rx_active, mask_wl, tx_active} = 3'b001;
    cfg = fdc_cfg_t'(6'b110001);
    tx_total = 10'h028;
    for (int k = 0; k < 2; k++) begin
      spi(8'hC2, 0, r);
      host.open_frame();
      host.shift(8'h80, 8, r);
      for (int i = 0; i < (k ? 5 : 17); i++) host.shift(8'hA0 + 8'(i), 8, r);
      host.close_frame();
      cyc(8);
      chk({tx_data, irq}, {8'hA0, 1'b0});
      pop(k + 1);
      chk({tx_data, irq}, {8'hA1 + 8'(k), 1'b1});
    end
    end_of_test();
  end
endmodule : tb
